// file: cpw_pkg.sv
// shared constants and types of the capture/compare/pwm unit
package cpw_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // control register layout
   localparam int MODE_LSB = 0;
   localparam int MODE_MSB = 3;
   localparam int DUTY_LSB_POS = 4;
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // mode field encodings
   localparam logic [3:0] MODE_OFF = 4'h0;
   localparam logic [3:0] MODE_CAP_FALL = 4'h4;
   localparam logic [3:0] MODE_CAP_RISE = 4'h5;
   localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
   localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
   localparam logic [3:0] MODE_CMP_HIGH = 4'h8;
   localparam logic [3:0] MODE_CMP_LOW = 4'h9;
   localparam logic [3:0] MODE_CMP_FLAG = 4'hA;
   localparam logic [3:0] MODE_CMP_SPECIAL = 4'hB;

   ////////////////////////////////////////////////////////////////////////////
   // counts in clock cycles and edges
   localparam logic [3:0] PRESC_LAST_4 = 4'h3;
   localparam logic [3:0] PRESC_LAST_16 = 4'hF;
   localparam logic [5:0] DIV_LAST_PS1 = 6'h03;
   localparam logic [5:0] DIV_LAST_PS4 = 6'h0F;
   localparam logic [5:0] DIV_LAST_PS16 = 6'h3F;

   // eight-bit timer prescale select
   localparam logic [1:0] T8_PS1 = 2'h0;
   localparam logic [1:0] T8_PS4 = 2'h1;

   // reset values
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [1:0] DUTY_LSB_RESET = 2'h0;
   localparam logic [3:0] PRESC_RESET = 4'h0;
   localparam logic [5:0] DIV_RESET = 6'h00;
   localparam logic [3:0] POST_RESET = 4'h0;

   ////////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [1:0] {
      CLS_OFF = 2'h0,
      CLS_CAPTURE = 2'h1,
      CLS_COMPARE = 2'h3,
      CLS_PWM = 2'h2
   } cpw_class_t;

   typedef struct packed {
      logic on;
      logic [1:0] ps;
      logic [3:0] post;
   } cpw_t8_cfg_t;

   typedef struct packed {
      logic wr_low;
      logic wr_high;
      logic [7:0] data;
   } cpw_byte_wr_t;

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic level;
   } cpw_sync_state_t;

   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] cap_low;
      logic [7:0] cap_high;
      logic [1:0] duty_lsb;
      logic unit_out;
      logic flag;
      logic [3:0] presc;
      logic pin_prev;
      logic eq_prev;
      logic [5:0] div;
      logic [7:0] tmr8;
      logic [3:0] post;
      logic pin_o;
      logic pin_oe;
      logic t8_flag;
      logic t16_rst;
   } cpw_state_t;

endpackage

// file: cpw_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none

module cpw_pin_sync (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_ce,
   // pad level
   input wire logic i_pin,
   // filtered level
   output logic o_level
);

   cpw_pkg::cpw_sync_state_t s;
   cpw_pkg::cpw_sync_state_t next_s;

   always_comb begin
      next_s = s;
      next_s.s1 = i_pin;
      next_s.s2 = s.s1;
      next_s.s3 = s.s2;
      // level moves only when the last two stages agree
      if (s.s2 == s.s3) begin
         next_s.level = s.s3;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         s <= '0;
      end else if (i_ce) begin
         s <= next_s;
      end
   end

   assign o_level = s.level;

endmodule
`default_nettype wire

// file: cpw_unit.sv
// capture/compare/pwm unit with one pin and an internal eight-bit timer
// Function
// - capture copies full sixteen-bit timer value
// - mode field selects capture edge and prescale
// - every capture sets flag; software clears it
// - new capture overwrites unread capture value
// - port write edge on driven pin captures
// - mode change may falsely set the flag
// - prescaler cleared when off or not capturing
// - capture prescale switch keeps prescaler count
// - compare match drives pin high, low, unchanged
// - compare match sets flag with pin action
// - zero control write forces compare latch low
// - pwm output with ten-bit duty resolution
// - zero control write forces pwm latch low
// - period is (period+1) times four times prescale
// - period end clears timer, sets pin unless zero
// - period end moves duty low byte to high
// - postscaler affects only eight-bit timer flag
// - special event match resets sixteen-bit timer
`timescale 1ns/10ps
`default_nettype none

module cpw_unit (
   // clock, reset, enable
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_ce,
   // software control
   input wire logic i_ctrl_wr,
   input wire logic [7:0] i_ctrl_data,
   input wire cpw_pkg::cpw_byte_wr_t i_byte_wr,
   input wire logic i_flag_clr,
   // timers
   input wire logic [15:0] i_timer16,
   input wire logic [7:0] i_period,
   input wire cpw_pkg::cpw_t8_cfg_t i_t8_cfg,
   // port and pin
   input wire logic i_pin,
   input wire logic i_port_data,
   input wire logic i_dir_in,
   output logic o_pin,
   output logic o_pin_oe,
   // status
   output logic [7:0] o_ctrl,
   output logic [15:0] o_capture_pair,
   output logic o_flag,
   output logic [7:0] o_timer8,
   output logic o_t8_flag,
   output logic o_t16_reset
);

   ////////////////////////////////////////////////////////////////////////////
   // functions

   // operating class of a mode field value
   function automatic cpw_pkg::cpw_class_t mode_class(input logic [3:0] mode);
      cpw_pkg::cpw_class_t cls;
      case (mode[3:2])
         2'h1: begin
            cls = cpw_pkg::CLS_CAPTURE;
         end
         2'h2: begin
            cls = cpw_pkg::CLS_COMPARE;
         end
         2'h3: begin
            cls = cpw_pkg::CLS_PWM;
         end
         default: begin
            cls = cpw_pkg::CLS_OFF;
         end
      endcase
      return cls;
   endfunction

   // last divider count before a timer increment
   function automatic logic [5:0] div_last(input logic [1:0] ps);
      logic [5:0] last;
      case (ps)
         cpw_pkg::T8_PS1: begin
            last = cpw_pkg::DIV_LAST_PS1;
         end
         cpw_pkg::T8_PS4: begin
            last = cpw_pkg::DIV_LAST_PS4;
         end
         default: begin
            last = cpw_pkg::DIV_LAST_PS16;
         end
      endcase
      return last;
   endfunction

   // two low-order timebase bits taken from the divider
   function automatic logic [1:0] div_ext(input logic [5:0] div, input logic [1:0] ps);
      logic [1:0] ext;
      case (ps)
         cpw_pkg::T8_PS1: begin
            ext = div[1:0];
         end
         cpw_pkg::T8_PS4: begin
            ext = div[3:2];
         end
         default: begin
            ext = div[5:4];
         end
      endcase
      return ext;
   endfunction

   // one-cycle change of a level towards the given value
   function automatic logic level_edge(input logic now, input logic prev, input logic lvl);
      return (now != prev) && (now == lvl);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // pin synchroniser

   logic pin_level;

   // a pad pulse shorter than two clocks never reaches the level
   cpw_pin_sync u_sync (
      .i_core_clk(i_core_clk),
      .i_nrst(i_nrst),
      .i_ce(i_ce),
      .i_pin(i_pin),
      .o_level(pin_level)
   );

   ////////////////////////////////////////////////////////////////////////////
   // state

   cpw_pkg::cpw_state_t s;
   cpw_pkg::cpw_state_t next_s;

   logic [3:0] mode;
   cpw_pkg::cpw_class_t cls;
   cpw_pkg::cpw_class_t next_cls;
   logic rise;
   logic fall;
   logic cap_event;
   logic cmp_eq;
   logic cmp_hit;
   logic t8_tick;
   logic period_end;
   logic [9:0] new_duty;
   logic [9:0] next_ext_tmr;
   logic set_flag;

   always_comb begin
      next_s = s;
      mode = s.ctrl[cpw_pkg::MODE_MSB:cpw_pkg::MODE_LSB];
      cls = mode_class(mode);
      cap_event = 1'b0;
      cmp_hit = 1'b0;
      t8_tick = 1'b0;
      period_end = 1'b0;
      set_flag = 1'b0;
      new_duty = {s.cap_low, s.ctrl[cpw_pkg::DUTY_LSB_POS +: 2]};
      next_s.t8_flag = 1'b0;
      next_s.t16_rst = 1'b0;

      // pad level includes our own drive, so port writes can make edges
      rise = level_edge(pin_level, s.pin_prev, 1'b1);
      fall = level_edge(pin_level, s.pin_prev, 1'b0);
      next_s.pin_prev = pin_level;

      // software byte writes; high byte is the duty latch in pwm mode
      if (i_byte_wr.wr_low) begin
         next_s.cap_low = i_byte_wr.data;
      end
      if (i_byte_wr.wr_high && cls != cpw_pkg::CLS_PWM) begin
         next_s.cap_high = i_byte_wr.data;
      end

      /////////////////////////////////////////////////////////////////////////
      // capture
      if (cls != cpw_pkg::CLS_CAPTURE) begin
         next_s.presc = cpw_pkg::PRESC_RESET;
      end else begin
         // prescaler count survives a switch between capture modes
         case (mode)
            cpw_pkg::MODE_CAP_FALL: begin
               cap_event = fall;
            end
            cpw_pkg::MODE_CAP_RISE: begin
               cap_event = rise;
            end
            cpw_pkg::MODE_CAP_RISE4: begin
               if (rise) begin
                  if (s.presc >= cpw_pkg::PRESC_LAST_4) begin
                     cap_event = 1'b1;
                     next_s.presc = cpw_pkg::PRESC_RESET;
                  end else begin
                     next_s.presc = s.presc + 4'h1;
                  end
               end
            end
            cpw_pkg::MODE_CAP_RISE16: begin
               if (rise) begin
                  if (s.presc == cpw_pkg::PRESC_LAST_16) begin
                     cap_event = 1'b1;
                  end
                  next_s.presc = s.presc + 4'h1;
               end
            end
            default: begin
               cap_event = 1'b0;
            end
         endcase
      end
      if (cap_event) begin
         next_s.cap_low = i_timer16[7:0];
         next_s.cap_high = i_timer16[15:8];
         set_flag = 1'b1;
      end

      /////////////////////////////////////////////////////////////////////////
      // compare
      cmp_eq = (i_timer16 == {s.cap_high, s.cap_low});
      next_s.eq_prev = cmp_eq;
      if (cls == cpw_pkg::CLS_COMPARE) begin
         // act once per entry into equality
         cmp_hit = cmp_eq & ~s.eq_prev;
      end
      if (cmp_hit) begin
         set_flag = 1'b1;
         case (mode)
            cpw_pkg::MODE_CMP_HIGH: begin
               next_s.unit_out = 1'b1;
            end
            cpw_pkg::MODE_CMP_LOW: begin
               next_s.unit_out = 1'b0;
            end
            cpw_pkg::MODE_CMP_SPECIAL: begin
               // separate pulse, never the timer overflow flag
               next_s.t16_rst = 1'b1;
            end
            cpw_pkg::MODE_CMP_FLAG: begin
               // flag only, pin keeps its level
               next_s.unit_out = s.unit_out;
            end
            default: begin
               next_s.unit_out = s.unit_out;
            end
         endcase
      end

      /////////////////////////////////////////////////////////////////////////
      // eight-bit timer: one increment per four clocks times prescale
      if (i_t8_cfg.on) begin
         if (s.div >= div_last(i_t8_cfg.ps)) begin
            t8_tick = 1'b1;
            next_s.div = cpw_pkg::DIV_RESET;
         end else begin
            next_s.div = s.div + 6'h01;
         end
      end
      if (t8_tick) begin
         if (s.tmr8 == i_period) begin
            period_end = 1'b1;
            next_s.tmr8 = cpw_pkg::BYTE_RESET;
            // postscaler only paces the timer flag
            if (s.post >= i_t8_cfg.post) begin
               next_s.post = cpw_pkg::POST_RESET;
               next_s.t8_flag = 1'b1;
            end else begin
               next_s.post = s.post + 4'h1;
            end
         end else begin
            next_s.tmr8 = s.tmr8 + 8'h01;
         end
      end

      /////////////////////////////////////////////////////////////////////////
      // pwm
      // next extended count: the pin is already low in the cycle the count meets the duty
      next_ext_tmr = {next_s.tmr8, div_ext(next_s.div, i_t8_cfg.ps)};
      if (cls == cpw_pkg::CLS_PWM) begin
         if (period_end) begin
            next_s.cap_high = new_duty[9:2];
            next_s.duty_lsb = new_duty[1:0];
            next_s.unit_out = (new_duty != 10'h000);
         end else if (next_ext_tmr == {s.cap_high, s.duty_lsb}) begin
            next_s.unit_out = 1'b0;
         end
      end

      /////////////////////////////////////////////////////////////////////////
      // control write and flag
      if (i_ctrl_wr) begin
         next_s.ctrl = i_ctrl_data;
         if (i_ctrl_data == cpw_pkg::CTRL_RESET) begin
            next_s.unit_out = 1'b0;
         end
      end
      if (i_flag_clr) begin
         next_s.flag = 1'b0;
      end
      // a set in the clearing cycle wins
      if (set_flag) begin
         next_s.flag = 1'b1;
      end

      // pin mux: unit latch in compare and pwm, port latch otherwise
      next_cls = mode_class(next_s.ctrl[cpw_pkg::MODE_MSB:cpw_pkg::MODE_LSB]);
      case (next_cls)
         cpw_pkg::CLS_COMPARE: begin
            next_s.pin_o = next_s.unit_out;
         end
         cpw_pkg::CLS_PWM: begin
            next_s.pin_o = next_s.unit_out;
         end
         default: begin
            next_s.pin_o = i_port_data;
         end
      endcase
      next_s.pin_oe = ~i_dir_in;
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
         s <= '0;
      end else if (i_ce) begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   assign o_pin = s.pin_o;
   assign o_pin_oe = s.pin_oe;
   assign o_ctrl = s.ctrl;
   assign o_capture_pair = {s.cap_high, s.cap_low};
   assign o_flag = s.flag;
   assign o_timer8 = s.tmr8;
   assign o_t8_flag = s.t8_flag;
   assign o_t16_reset = s.t16_rst;

endmodule
`default_nettype wire

// file: cpw_unit_checker.sv
// port assertions of the capture/compare/pwm unit
`timescale 1ns/10ps
`default_nettype none
module cpw_unit_checker (
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_nrst,
   input wire logic i_ce,
   // inputs
   input wire logic i_ctrl_wr,
   input wire logic [7:0] i_ctrl_data,
   input wire cpw_pkg::cpw_byte_wr_t i_byte_wr,
   input wire logic i_flag_clr,
   input wire logic [15:0] i_timer16,
   input wire logic [7:0] i_period,
   input wire logic i_dir_in,
   // outputs
   input wire logic o_pin,
   input wire logic o_pin_oe,
   input wire logic [7:0] o_ctrl,
   input wire logic [15:0] o_capture_pair,
   input wire logic o_flag,
   input wire logic [7:0] o_timer8,
   input wire logic o_t16_reset
);
   logic [3:0] md;
   assign md = o_ctrl[3:0];
   default clocking cb @(posedge i_core_clk);
   endclocking
   default disable iff (!i_nrst);
   ////////////////////////////////////////
   // first cycle of equality in a held compare mode
   sequence s_hit(logic [3:0] m);
      i_ce && md == m && $past(md) == m && i_timer16 == o_capture_pair
         && $past(i_timer16) != $past(o_capture_pair);
   endsequence
   property p_ctrl;
      i_ce && i_ctrl_wr |=> o_ctrl == $past(i_ctrl_data);
   endproperty
   a_ctrl: assert property (p_ctrl) else $error("ctrl write lost");
   property p_flag;
      o_flag && !i_flag_clr |=> o_flag;
   endproperty
   a_flag: assert property (p_flag) else $error("flag dropped");
   property p_cap;
      $past(i_nrst) && $past(o_ctrl[3:2]) == 2'h1 && !$past(i_byte_wr.wr_low)
         && !$past(i_byte_wr.wr_high) && o_capture_pair != $past(o_capture_pair)
         |-> o_capture_pair == $past(i_timer16) && o_flag;
   endproperty
   a_cap: assert property (p_cap) else $error("bad capture");
   property p_high;
      s_hit(4'h8) |=> o_pin && o_flag;
   endproperty
   a_high: assert property (p_high) else $error("match not high");
   property p_low;
      s_hit(4'h9) |=> !o_pin && o_flag;
   endproperty
   a_low: assert property (p_low) else $error("match not low");
   property p_spc;
      s_hit(4'hB) |=> o_t16_reset ##1 !o_t16_reset;
   endproperty
   a_spc: assert property (p_spc) else $error("no timer reset");
   property p_t8;
      $past(i_nrst) && o_timer8 != $past(o_timer8) |-> o_timer8 == $past(o_timer8) + 8'h01
         || o_timer8 == 8'h00 && $past(o_timer8) == $past(i_period);
   endproperty
   a_t8: assert property (p_t8) else $error("timer step wrong");
   property p_oe;
      $past(i_nrst) && $past(i_ce) |-> o_pin_oe == !$past(i_dir_in);
   endproperty
   a_oe: assert property (p_oe) else $error("enable wrong");
   c_cap: cover property (md == 4'h7 && $rose(o_flag));
   c_spc: cover property (o_t16_reset);
   c_pwm: cover property (md == 4'hC && $rose(o_pin));
endmodule
bind cpw_unit cpw_unit_checker u_cpw_unit_checker (.i_core_clk, .i_nrst, .i_ce, .i_ctrl_wr,
   .i_ctrl_data, .i_byte_wr, .i_flag_clr, .i_timer16, .i_period, .i_dir_in, .o_pin, .o_pin_oe,
   .o_ctrl, .o_capture_pair, .o_flag, .o_timer8, .o_t16_reset);
`default_nettype wire

// file: cpw_pin_model.sv
// external source or load on the unit pin
`timescale 1ns/10ps
`default_nettype none
module cpw_pin_model (
   // device side
   input wire logic i_drive,
   input wire logic i_oe,
   // external source
   input wire logic i_src,
   // pad level
   output logic o_pad
);
   // pad follows the unit while it drives, else the source
   assign o_pad = i_oe ? i_drive : i_src;
endmodule
`default_nettype wire

// file: cpw_unit_bench.sv
// self-checking bench of the capture/compare/pwm unit
`timescale 1ns/10ps
`default_nettype none
module cpw_unit_bench;
   logic i_core_clk, i_nrst, i_ctrl_wr, i_flag_clr, i_pin, i_port_data, i_dir_in, src, p;
   logic [7:0] i_ctrl_data, i_period, o_ctrl, o_timer8;
   logic [15:0] i_timer16, o_capture_pair;
   logic o_pin, o_pin_oe, o_flag, o_t8_flag, o_t16_reset;
   cpw_pkg::cpw_byte_wr_t i_byte_wr;
   cpw_pkg::cpw_t8_cfg_t i_t8_cfg;
   int n_errors, n_checks, h, r, f, n;
   logic [3:0] cm [7] = '{4'h8, 4'hA, 4'h9, 4'h8, 4'h0, 4'hA, 4'hB};
   // expected pin after each compare match above
   logic cp [7] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
   // ps, post, duty byte, duty lsbs, high count, rises, timer flags
   int pw [4][7] = '{'{0, 1, 1, 0, 32, 8, 4}, '{0, 0, 1, 1, 40, 8, 8},
      '{0, 0, 0, 0, 0, 0, 8}, '{1, 0, 1, 0, 32, 2, 2}};
   cpw_unit u_cpw_unit (.i_core_clk, .i_nrst, .i_ce(1'b1), .i_ctrl_wr, .i_ctrl_data, .i_byte_wr,
      .i_flag_clr, .i_timer16, .i_period, .i_t8_cfg, .i_pin, .i_port_data, .i_dir_in, .o_pin,
      .o_pin_oe, .o_ctrl, .o_capture_pair, .o_flag, .o_timer8, .o_t8_flag, .o_t16_reset);
   cpw_pin_model u_cpw_pin_model (.i_drive(o_pin), .i_oe(o_pin_oe), .i_src(src), .o_pad(i_pin));
   ////////////////////////////////////////
   task automatic tick(input int k);
      repeat (k) @(negedge i_core_clk);
   endtask
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic wr_ctrl(input logic [7:0] d);
      i_ctrl_wr = 1;
      i_ctrl_data = d;
      tick(1);
      i_ctrl_wr = 0;
      tick(1);
   endtask
   task automatic wr_byte(input logic hi, input logic [7:0] d);
      i_byte_wr = {!hi, hi, d};
      tick(1);
      i_byte_wr = '0;
      tick(1);
   endtask
   task automatic clr_flag;
      i_flag_clr = 1;
      tick(1);
      i_flag_clr = 0;
   endtask
   // source pulses, timer moves before each one
   task automatic pulse(input int k);
      repeat (k) begin
         i_timer16 = i_timer16 + 16'h0111;
         src = 1;
         tick(5);
         src = 0;
         tick(5);
      end
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      i_core_clk = 0;
      forever #5 i_core_clk = ~i_core_clk;
   end
   initial begin
      {i_nrst, i_ctrl_wr, i_flag_clr, i_port_data, src, i_ctrl_data, i_byte_wr, i_timer16} = '0;
      i_dir_in = 1;
      i_period = 8'h01;
      i_t8_cfg = '{1'b1, 2'h0, 4'h0};
      tick(6);
      i_nrst = 1;
      cmp("reset", 0, {o_ctrl, o_capture_pair, o_flag, o_pin_oe});
      for (int k = 0; k < 4; k++) begin
         wr_ctrl(8'h00);
         wr_ctrl({4'h0, 4'h4 + 4'(k)});
         clr_flag();
         n = (k < 2) ? 1 : 1 << (2 * k - 2);
         pulse(n - 1);
         cmp("flag early", 0, o_flag);
         pulse(1);
         cmp("capture", i_timer16, o_capture_pair);
         cmp("flag", 1, o_flag);
         pulse(n);
         cmp("overwrite", i_timer16, o_capture_pair);
      end
      wr_ctrl(8'h06);
      pulse(2);
      wr_ctrl(8'h07);
      clr_flag();
      pulse(13);
      cmp("presc kept", 0, o_flag);
      pulse(1);
      cmp("presc kept", 1, o_flag);
      pulse(2);
      wr_ctrl(8'h00);
      wr_ctrl(8'h06);
      clr_flag();
      pulse(3);
      cmp("presc clear", 0, o_flag);
      pulse(1);
      cmp("presc clear", 1, o_flag);
      wr_ctrl(8'h05);
      i_dir_in = 0;
      tick(2);
      clr_flag();
      i_port_data = 1;
      tick(6);
      cmp("port capture", 1, o_flag);
      cmp("port value", i_timer16, o_capture_pair);
      $display("test capture done");
      i_port_data = 0;
      wr_byte(0, 8'h34);
      wr_byte(1, 8'h12);
      i_timer16 = 16'h1000;
      for (int k = 0; k < 7; k++) begin
         wr_ctrl({4'h0, cm[k]});
         clr_flag();
         tick(2);
         i_timer16 = 16'h1234;
         tick(1);
         cmp("compare pin", cp[k], o_pin);
         cmp("compare flag", cm[k] != 4'h0, o_flag);
         cmp("event trigger", cm[k] == 4'hB, o_t16_reset);
         i_timer16 = 16'h1000;
      end
      $display("test compare done");
      for (int k = 0; k < 4; k++) begin
         wr_ctrl(8'h00);
         tick(1);
         cmp("pwm off", 0, o_pin);
         wr_byte(0, 8'(pw[k][2]));
         i_t8_cfg = '{1'b1, 2'(pw[k][0]), 4'(pw[k][1])};
         wr_ctrl({2'h0, 2'(pw[k][3]), 4'hC});
         tick(80);
         cmp("duty latch", pw[k][2], o_capture_pair[15:8]);
         p = o_pin;
         {h, r, f} = '0;
         repeat (64) begin
            tick(1);
            h += int'(o_pin === 1'b1);
            r += int'(o_pin === 1'b1 && p === 1'b0);
            f += int'(o_t8_flag === 1'b1);
            p = o_pin;
         end
         cmp("pwm high", pw[k][4], h);
         cmp("pwm period", pw[k][5], r);
         cmp("timer flag", pw[k][6], f);
      end
      $display("test pwm done");
      summarize();
   end
endmodule
`default_nettype wire
